// ===== core/dpc_top.sv
// converter pwm control and monitor block with axi4-lite register slave
// Behaviour
// (R1) Read-only 8-bit fifth sense transistor current, linear 0x00..0xff, 0.316 mA steps.
// (R2) Read-only 8-bit sixth sense transistor current on the same scale.
// (R3) Switching period is the 8-bit period code in 61.035 ns steps, 0x40..0xff.
// (R4) Period bit 6 always reads one and ignores writes, giving two ranges.
// (R5) Software picks short range for field-effect, long range for bipolar switches.
// (R6) Writing one to delay bit 7 starts calibration; reads one while running.
// (R7) Read-only bit 5 reports feed-forward to drive polarity relation.
// (R8) Polarity bit zero means inverted feed-forward, one means same polarity.
// (R9) Minimum off time is (off-time code plus four) times 61.035 ns.
// (R10) Pulse width code minus off code minus four gives on time in steps.
// (R11) Calibration start bit clears itself when calibration finishes.
`timescale 1ns/1ns
`default_nettype none
module dpc_top
    import dpc_pkg::*;
#(
    parameter int          CAL_STEPS     = dpc_pkg::CAL_STEPS_DFLT,
    parameter logic        FF_SAME_POL   = 1'b0
) (
    input  wire logic                     clk_in,
    input  wire logic                     sys_rst_in,
    // axi4-lite slave
    input  wire logic [dpc_pkg::ADDR_W-1:0] s_axi_awaddr_in,
    input  wire logic                     s_axi_awvalid_in,
    output logic                          s_axi_awready_out,
    input  wire logic [31:0]              s_axi_wdata_in,
    input  wire logic [3:0]               s_axi_wstrb_in,
    input  wire logic                     s_axi_wvalid_in,
    output logic                          s_axi_wready_out,
    output logic [1:0]                    s_axi_bresp_out,
    output logic                          s_axi_bvalid_out,
    input  wire logic                     s_axi_bready_in,
    input  wire logic [dpc_pkg::ADDR_W-1:0] s_axi_araddr_in,
    input  wire logic                     s_axi_arvalid_in,
    output logic                          s_axi_arready_out,
    output logic [31:0]                   s_axi_rdata_out,
    output logic [1:0]                    s_axi_rresp_out,
    output logic                          s_axi_rvalid_out,
    input  wire logic                     s_axi_rready_in,
    // converter side
    input  wire logic [7:0]               switch5_current_in,
    input  wire logic [7:0]               switch6_current_in,
    input  wire logic                     peak_trip_in,
    input  wire logic                     peak_cal_done_in,
    output logic                          peak_cal_active_out,
    output logic                          converter_drive_out,
    output logic                          feedforward_pin_out
);
    import dpc_pkg::*;

    // register index from a byte address, used for both read and write decode
    function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] addr);
        reg_index = addr[ADDR_W-1:ADDR_LSB];
    endfunction

    function automatic logic is_mapped(input logic [7:0] idx);
        is_mapped = (idx == IDX_SW5_CURRENT) || (idx == IDX_SW6_CURRENT) ||
                    (idx == IDX_PWM_PERIOD) || (idx == IDX_SW_DELAY) ||
                    (idx == IDX_PULSE_WIDTH);
    endfunction

    // ------------------------------------------------------------------
    // state declarations
    dpc_ctrl_t          ctrl_reg;
    logic               cal_busy_reg;
    logic [7:0]         pulse_width_reg;
    dpc_sense_t         sense_meta_reg;
    dpc_sense_t         sense_reg;
    logic [1:0]         trip_sync_reg;
    logic [1:0]         caldone_sync_reg;
    logic [16:0]        step_acc_reg;
    logic               step_tick_reg;
    dpc_phase_t         phase_reg;
    logic [7:0]         phase_cnt_reg;
    logic [7:0]         on_cnt_reg;
    logic [15:0]        cal_cnt_reg;
    logic               drive_reg;
    logic               ff_reg;

    logic               aw_held_reg;
    logic [ADDR_W-1:0]  aw_addr_reg;
    logic               w_held_reg;
    logic [31:0]        w_data_reg;
    logic [3:0]         w_strb_reg;
    logic               bvalid_reg;
    logic [1:0]         bresp_reg;
    logic               rvalid_reg;
    logic [31:0]        rdata_reg;
    logic [1:0]         rresp_reg;

    // ------------------------------------------------------------------
    // input synchronisers; the first stage feeds only the second
    always_ff @(posedge clk_in) begin
        sense_meta_reg   <= {switch5_current_in, switch6_current_in};
        sense_reg        <= sense_meta_reg; // R1 R2
        trip_sync_reg    <= {trip_sync_reg[0], peak_trip_in};
        caldone_sync_reg <= {caldone_sync_reg[0], peak_cal_done_in};
    end

    wire logic trip_s    = trip_sync_reg[1];
    wire logic caldone_s = caldone_sync_reg[1];

    // ------------------------------------------------------------------
    // axi write path: address and data are taken independently
    assign s_axi_awready_out = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready_out  = !w_held_reg && !bvalid_reg;

    wire logic              aw_take  = s_axi_awvalid_in && s_axi_awready_out;
    wire logic              w_take   = s_axi_wvalid_in && s_axi_wready_out;
    wire logic              aw_have  = aw_held_reg || aw_take;
    wire logic              w_have   = w_held_reg || w_take;
    wire logic              wr_fire  = aw_have && w_have && !bvalid_reg;
    wire logic [ADDR_W-1:0] wr_addr  = aw_held_reg ? aw_addr_reg : s_axi_awaddr_in;
    wire logic [31:0]       wr_data  = w_held_reg ? w_data_reg : s_axi_wdata_in;
    wire logic [3:0]        wr_strb  = w_held_reg ? w_strb_reg : s_axi_wstrb_in;
    wire logic [7:0]        wr_idx   = reg_index(wr_addr);
    wire logic              wr_lane0 = wr_fire && wr_strb[0];
    wire logic              wr_per   = wr_lane0 && (wr_idx == IDX_PWM_PERIOD);
    wire logic              wr_dly   = wr_lane0 && (wr_idx == IDX_SW_DELAY);
    wire logic              cal_go   = wr_dly && wr_data[DLY_CAL_BIT]; // R6

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
            aw_addr_reg <= '0;
            w_data_reg  <= '0;
            w_strb_reg  <= '0;
        end else begin
            if (aw_take) begin
                aw_addr_reg <= s_axi_awaddr_in;
            end
            if (w_take) begin
                w_data_reg <= s_axi_wdata_in;
                w_strb_reg <= s_axi_wstrb_in;
            end
            if (wr_fire) begin
                aw_held_reg <= 1'b0;
                w_held_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= is_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
            end else begin
                aw_held_reg <= aw_have;
                w_held_reg  <= w_have;
                if (s_axi_bready_in) begin
                    bvalid_reg <= 1'b0;
                end
            end
        end
    end

    assign s_axi_bvalid_out = bvalid_reg;
    assign s_axi_bresp_out  = bresp_reg;

    // ------------------------------------------------------------------
    // control registers; period bit 6 is stored as one on every write and always reads one
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            ctrl_reg.period_code       <= RST_PWM_PERIOD;
            ctrl_reg.min_off_time_code <= RST_MIN_OFF;
        end else begin
            if (wr_per) begin
                ctrl_reg.period_code <= wr_data[7:0] | (8'h01 << PER_FIXED_BIT); // R3 R4
            end
            if (wr_dly) begin
                ctrl_reg.min_off_time_code <= wr_data[4:0]; // R9
            end
        end
    end

    // ------------------------------------------------------------------
    // axi read path: one read at a time, answer the cycle after the address
    wire logic [7:0] rd_idx  = reg_index(s_axi_araddr_in);
    wire logic       rd_take = s_axi_arvalid_in && s_axi_arready_out;
    wire logic [7:0] dly_rd  = {cal_busy_reg, 1'b0, FF_SAME_POL, ctrl_reg.min_off_time_code}; // R6 R7 R8

    assign s_axi_arready_out = !rvalid_reg;

    logic [7:0] rd_byte;
    always_comb begin
        case (rd_idx)
            IDX_SW5_CURRENT: rd_byte = sense_reg.switch5_current; // R1
            IDX_SW6_CURRENT: rd_byte = sense_reg.switch6_current; // R2
            IDX_PWM_PERIOD:  rd_byte = ctrl_reg.period_code;     // R4
            IDX_SW_DELAY:    rd_byte = dly_rd;
            IDX_PULSE_WIDTH: rd_byte = pulse_width_reg;          // R10
            default:         rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= '0;
            rresp_reg  <= RESP_OKAY;
        end else if (rd_take) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= {24'h000000, rd_byte};
            rresp_reg  <= is_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready_in) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign s_axi_rvalid_out = rvalid_reg;
    assign s_axi_rdata_out  = rdata_reg;
    assign s_axi_rresp_out  = rresp_reg;

    // ------------------------------------------------------------------
    // 61.035 ns step tick from a picosecond phase accumulator, exact on average
    wire logic [16:0] acc_sum  = step_acc_reg + CLK_PS;
    wire logic        acc_wrap = (acc_sum >= STEP_PS);

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            step_acc_reg  <= '0;
            step_tick_reg <= 1'b0;
        end else begin
            step_acc_reg  <= acc_wrap ? 17'(acc_sum - STEP_PS) : acc_sum; // R3 R9
            step_tick_reg <= acc_wrap;
        end
    end

    // ------------------------------------------------------------------
    // pwm timing decode
    wire logic [7:0] off_steps  = {3'b000, ctrl_reg.min_off_time_code} + {3'b000, OFF_TIME_BIAS}; // R9
    wire logic [7:0] on_limit   = ctrl_reg.period_code - off_steps; // R9
    wire logic [7:0] period_end = ctrl_reg.period_code - 8'h01;     // R3
    wire logic       last_step  = step_tick_reg && (phase_cnt_reg == period_end);
    wire logic       cal_finish = cal_busy_reg && (cal_cnt_reg == 16'(CAL_STEPS - 1) || caldone_s);
    wire logic [7:0] pw_code    = on_cnt_reg + off_steps; // R10

    // calibration busy flag; a fresh start wins over completion
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            cal_busy_reg <= 1'b0;
        end else if (cal_go) begin
            cal_busy_reg <= 1'b1; // R6
        end else if (cal_finish && (step_tick_reg || caldone_s)) begin
            cal_busy_reg <= 1'b0; // R11
        end
    end

    // calibration step counter
    always_ff @(posedge clk_in) begin
        if (sys_rst_in || cal_go || !cal_busy_reg) begin
            cal_cnt_reg <= '0;
        end else if (step_tick_reg) begin
            cal_cnt_reg <= cal_cnt_reg + 16'h0001;
        end
    end

    // switching cycle sequencer: on from cycle start until trip or limit, then off
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            phase_reg       <= PH_OFF;
            phase_cnt_reg   <= '0;
            on_cnt_reg      <= '0;
            pulse_width_reg <= RST_PULSE_WIDTH;
        end else begin
            case (phase_reg)
                PH_CAL: begin
                    phase_cnt_reg <= '0;
                    on_cnt_reg    <= '0;
                    if (!cal_busy_reg) begin
                        phase_reg <= PH_OFF;
                    end
                end
                PH_ON: begin
                    if (cal_busy_reg) begin
                        phase_reg <= PH_CAL;
                    end else if (trip_s || (phase_cnt_reg >= on_limit)) begin
                        phase_reg <= PH_OFF; // R9
                    end else if (step_tick_reg) begin
                        on_cnt_reg    <= on_cnt_reg + 8'h01;
                        phase_cnt_reg <= phase_cnt_reg + 8'h01;
                    end
                end
                PH_OFF: begin
                    if (cal_busy_reg) begin
                        phase_reg <= PH_CAL;
                    end else if (last_step) begin
                        phase_cnt_reg   <= '0;
                        on_cnt_reg      <= '0;
                        pulse_width_reg <= pw_code; // R10
                        phase_reg       <= PH_ON;
                    end else if (step_tick_reg) begin
                        phase_cnt_reg <= phase_cnt_reg + 8'h01; // R3
                    end
                end
                default: begin
                    phase_reg <= PH_OFF;
                end
            endcase
        end
    end

    // drive and feed-forward pins from flip-flops; polarity fixed by strap parameter
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            drive_reg <= 1'b0;
            ff_reg    <= !FF_SAME_POL;
        end else begin
            drive_reg <= (phase_reg == PH_ON);
            ff_reg    <= (phase_reg == PH_ON) ~^ FF_SAME_POL; // R7 R8
        end
    end

    assign converter_drive_out = drive_reg;
    assign feedforward_pin_out = ff_reg;
    assign peak_cal_active_out = cal_busy_reg;
endmodule
`default_nettype wire

// ===== inc/dpc_pkg.sv
// constants and types shared by the converter pwm control and monitor block
package dpc_pkg;
    // register indices; the byte address is four times the index
    localparam logic [7:0]  IDX_SW5_CURRENT  = 8'h58;
    localparam logic [7:0]  IDX_SW6_CURRENT  = 8'h59;
    localparam logic [7:0]  IDX_PWM_PERIOD   = 8'h5c;
    localparam logic [7:0]  IDX_SW_DELAY     = 8'h5d;
    localparam logic [7:0]  IDX_PULSE_WIDTH  = 8'h5e;
    localparam int          ADDR_LSB         = 2;
    localparam int          ADDR_W           = 10;

    // reset values
    localparam logic [7:0]  RST_PWM_PERIOD   = 8'hff;
    localparam logic [4:0]  RST_MIN_OFF      = 5'h14;
    localparam logic [7:0]  RST_PULSE_WIDTH  = 8'h00;

    // field positions
    localparam int          PER_FIXED_BIT    = 6;
    localparam int          DLY_CAL_BIT      = 7;
    localparam int          DLY_POL_BIT      = 5;
    localparam logic [4:0]  OFF_TIME_BIAS    = 5'h04;

    // time base: one step is 61.035 ns, accumulated in picoseconds
    localparam int          STEP_TIME_PS     = 61035;
    localparam int          CLK_PERIOD_PS    = 4000;
    localparam logic [16:0] STEP_PS          = 17'(STEP_TIME_PS);
    localparam logic [16:0] CLK_PS           = 17'(CLK_PERIOD_PS);

    // default length of the peak monitor calibration, in time steps
    localparam int          CAL_STEPS_DFLT   = 256;

    // axi response codes
    localparam logic [1:0]  RESP_OKAY        = 2'b00;
    localparam logic [1:0]  RESP_SLVERR      = 2'b10;

    // software-written control image
    typedef struct packed {
        logic [7:0] period_code;
        logic [4:0] min_off_time_code;
    } dpc_ctrl_t;

    // sensed values after synchronisation
    typedef struct packed {
        logic [7:0] switch5_current;
        logic [7:0] switch6_current;
    } dpc_sense_t;

    typedef enum logic [1:0] {
        PH_CAL,
        PH_ON,
        PH_OFF
    } dpc_phase_t;
endpackage

// ===== tb/dpc_top_props.sv
// assertion checker for the converter pwm control block
`timescale 1ns/1ns
`default_nettype none
module dpc_top_props
    import dpc_pkg::*;
#(
    parameter int   CAL_STEPS   = CAL_STEPS_DFLT,
    parameter logic FF_SAME_POL = 1'b0
) (
    input wire logic        clk_in,
    input wire logic        sys_rst_in,
    input wire logic        s_axi_awvalid_in,
    input wire logic        s_axi_awready_out,
    input wire logic        s_axi_wvalid_in,
    input wire logic        s_axi_wready_out,
    input wire logic [1:0]  s_axi_bresp_out,
    input wire logic        s_axi_bvalid_out,
    input wire logic        s_axi_bready_in,
    input wire logic        s_axi_arvalid_in,
    input wire logic        s_axi_arready_out,
    input wire logic [31:0] s_axi_rdata_out,
    input wire logic        s_axi_rvalid_out,
    input wire logic        s_axi_rready_in,
    input wire logic        peak_cal_active_out,
    input wire logic        converter_drive_out,
    input wire logic        feedforward_pin_out
);
    logic [15:0] cal_cnt_reg;
    logic [15:0] low_cnt_reg;
    logic        fell_reg;
    // length of a running calibration and of the current drive low time
    always_ff @(posedge clk_in) begin
        cal_cnt_reg <= (sys_rst_in || !peak_cal_active_out) ? 16'h0 : cal_cnt_reg + 16'h1;
        low_cnt_reg <= (sys_rst_in || converter_drive_out) ? 16'h0 : low_cnt_reg + 16'h1;
        fell_reg    <= sys_rst_in ? 1'b0 : (fell_reg || (converter_drive_out && !peak_cal_active_out));
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    sequence wr_both_s; s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out; endsequence
    sequence rd_take_s; s_axi_arvalid_in && s_axi_arready_out; endsequence
    wr_answer_a: assert property (wr_both_s |=> s_axi_bvalid_out) else $error("write answer late");
    b_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
        else $error("write response dropped");
    wr_block_a: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
        else $error("write taken during response");
    rd_answer_a: assert property (rd_take_s |=> s_axi_rvalid_out) else $error("read answer late");
    r_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
        else $error("read data dropped");
    rd_upper_a: assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h0 && !s_axi_arready_out)
        else $error("read upper bits set");
    ff_pol_a: assert property (feedforward_pin_out == (converter_drive_out ~^ FF_SAME_POL))
        else $error("feed forward polarity wrong");
    cal_quiet_a: assert property (peak_cal_active_out && $past(peak_cal_active_out, 2) |-> !converter_drive_out)
        else $error("drive during calibration");
    cal_end_a: assert property (cal_cnt_reg <= 16'(CAL_STEPS * 16 + 8))
        else $error("calibration never ends");
    off_min_a: assert property ($rose(converter_drive_out) && fell_reg |-> low_cnt_reg >= 16'd59)
        else $error("off time too short");
endmodule
bind dpc_top dpc_top_props #(.CAL_STEPS(CAL_STEPS), .FF_SAME_POL(FF_SAME_POL)) props_u (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .s_axi_awvalid_in(s_axi_awvalid_in),
    .s_axi_awready_out(s_axi_awready_out), .s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out),
    .s_axi_bresp_out(s_axi_bresp_out), .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
    .s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out), .s_axi_rdata_out(s_axi_rdata_out),
    .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in), .peak_cal_active_out(peak_cal_active_out),
    .converter_drive_out(converter_drive_out), .feedforward_pin_out(feedforward_pin_out));
`default_nettype wire

// ===== tb/dpc_conv_model.sv
// behavioural model of the switching transistor and its sense circuitry
`timescale 1ns/1ns
`default_nettype none
module dpc_conv_model (
    input  wire logic        clk_in,
    input  wire logic        drive_in,
    input  wire logic        cal_active_in,
    input  wire logic [7:0]  i5_set_in,
    input  wire logic [7:0]  i6_set_in,
    input  wire logic [15:0] trip_clk_in,     // on clocks before the peak trips, zero never trips
    input  wire logic        cal_answer_in,   // low leaves the calibration to run out
    output logic [7:0]       switch5_current_out = 8'h00,
    output logic [7:0]       switch6_current_out = 8'h00,
    output logic             peak_trip_out = 1'b0,
    output logic             peak_cal_done_out = 1'b0
);
    int on_cnt = 0;
    int cal_cnt = 0;
    // currents follow the set points; trip and done come after a delay
    always @(posedge clk_in) begin
        switch5_current_out <= i5_set_in;
        switch6_current_out <= i6_set_in;
        on_cnt = drive_in ? on_cnt + 1 : 0;
        peak_trip_out <= (trip_clk_in != 16'h0) && (on_cnt >= int'(trip_clk_in));
        cal_cnt = cal_active_in ? cal_cnt + 1 : 0;
        peak_cal_done_out <= cal_answer_in && (cal_cnt >= 10);
    end
endmodule
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for the converter pwm control block
`timescale 1ns/1ns
`default_nettype none
module tb;
    import dpc_pkg::*;
    logic              clk_in = 1'b0, sys_rst_in = 1'b1;
    logic [9:0]        awaddr = '0, araddr = '0;
    logic              awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, cal_ans = 0;
    logic              bvalid, awready, wready, arready, rvalid, drive, ff, cal_act, trip, cal_done;
    logic [31:0]       wdata = '0, rdata, rd_word, seed = 32'h8f49fabf;
    logic [1:0]        bresp, rresp, rd_resp;
    logic [7:0]        i5_set = '0, i6_set = '0, i5, i6;
    logic [15:0]       trip_clk = '0;
    int                failures = 0, comparisons = 0, cycles = 0, hi, lo, e;
    int                ref_reg [int];   // expected register image by byte address
    dpc_top #(.CAL_STEPS(4), .FF_SAME_POL(1'b0)) dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(4'h1), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
        .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
        .s_axi_rready_in(rready), .switch5_current_in(i5), .switch6_current_in(i6), .peak_trip_in(trip),
        .peak_cal_done_in(cal_done), .peak_cal_active_out(cal_act), .converter_drive_out(drive),
        .feedforward_pin_out(ff));
    dpc_conv_model conv_u (.clk_in(clk_in), .drive_in(drive), .cal_active_in(cal_act), .i5_set_in(i5_set),
        .i6_set_in(i6_set), .trip_clk_in(trip_clk), .cal_answer_in(cal_ans), .switch5_current_out(i5),
        .switch6_current_out(i6), .peak_trip_out(trip), .peak_cal_done_out(cal_done));
    // clock and hang guard
    initial begin
        forever #2 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 60000) begin
            failures++;
            finish_test();
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [9:0] ba(input logic [7:0] i);
        return {i, 2'b00};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("failures=%0d comparisons=%0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // bus master: hold each channel until taken, response ends the cycle
    task automatic axi_write(input logic [9:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_p, w_p;
        @(posedge clk_in);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
        aw_p = 1;
        w_p = 1;
        forever begin
            @(posedge clk_in);
            if (aw_p && awready === 1'b1) begin
                awvalid <= 1'b0;
                aw_p = 0;
            end
            if (w_p && wready === 1'b1) begin
                wvalid <= 1'b0;
                w_p = 0;
            end
            if (bvalid === 1'b1) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask
    task automatic axi_read(input logic [9:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_in);
        {araddr, arvalid, rready} <= {a, 2'b11};
        forever begin
            @(posedge clk_in);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                {d, r} = {rdata, rresp};
                rready <= 1'b0;
                break;
            end
        end
    endtask
    // register accesses compared with the behavioural image
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_write(a, d, r);
        check({30'h0, r}, ref_reg.exists(a) ? 32'(RESP_OKAY) : 32'(RESP_SLVERR));
        if (a == ba(IDX_PWM_PERIOD)) ref_reg[a] = (d & 32'hff) | 32'h40;
        if (a == ba(IDX_SW_DELAY)) ref_reg[a] = d & 32'h9f;
    endtask
    task automatic rd(input logic [9:0] a);
        logic [31:0] d;
        logic [1:0]  r;
        axi_read(a, d, r);
        check(d, ref_reg.exists(a) ? 32'(ref_reg[a]) : 32'h0);
        check({30'h0, r}, ref_reg.exists(a) ? 32'(RESP_OKAY) : 32'(RESP_SLVERR));
    endtask
    // one full switching cycle: on clocks then off clocks
    task automatic measure();
        while (drive !== 1'b1) @(posedge clk_in);
        while (drive === 1'b1) @(posedge clk_in);
        while (drive !== 1'b1) @(posedge clk_in);
        for (hi = 0; drive === 1'b1; hi++) @(posedge clk_in);
        for (lo = 0; drive !== 1'b1; lo++) @(posedge clk_in);
    endtask
    // main sequence
    initial begin
        ref_reg[ba(IDX_SW5_CURRENT)] = 0;
        ref_reg[ba(IDX_SW6_CURRENT)] = 0;
        ref_reg[ba(IDX_PWM_PERIOD)] = 8'hff;
        ref_reg[ba(IDX_SW_DELAY)] = 8'h14;
        ref_reg[ba(IDX_PULSE_WIDTH)] = 0;
        repeat (6) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        foreach (ref_reg[k]) rd(10'(k));
        rd(10'h100);
        wr(10'h100, 32'h55);
        for (int k = 0; k < 3; k++) begin
            seed = lfsr(seed);
            {i6_set, i5_set} <= seed[15:0];
            ref_reg[ba(IDX_SW5_CURRENT)] = seed[7:0];
            ref_reg[ba(IDX_SW6_CURRENT)] = seed[15:8];
            repeat (4) @(posedge clk_in);
            rd(ba(IDX_SW5_CURRENT));
            rd(ba(IDX_SW6_CURRENT));
            wr(ba(IDX_PWM_PERIOD), (k == 2) ? seed[31:24] : 32'(8'h3f << (k * 2)));
            rd(ba(IDX_PWM_PERIOD));
        end
        wr(ba(IDX_SW_DELAY), 32'h23);
        rd(ba(IDX_SW_DELAY));
        for (int k = 0; k < 3; k++) begin
            trip_clk <= (k == 2) ? 16'd100 : 16'd0;
            wr(ba(IDX_PWM_PERIOD), (k == 1) ? 32'hc0 : 32'h40);
            wr(ba(IDX_SW_DELAY), (k == 1) ? 32'h1f : 32'h00);
            measure();
            check({31'h0, ff}, 32'h0);
            e = (ref_reg[ba(IDX_SW_DELAY)] + 4) * STEP_TIME_PS / CLK_PERIOD_PS;
            if (k < 2) check(32'(lo >= e - 16 && lo <= e + 16), 32'h1);
            ref_reg[ba(IDX_PULSE_WIDTH)] = ref_reg[ba(IDX_PWM_PERIOD)];
            if (k < 2) rd(ba(IDX_PULSE_WIDTH));
            axi_read(ba(IDX_PULSE_WIDTH), rd_word, rd_resp);
            e = (int'(rd_word) - ref_reg[ba(IDX_SW_DELAY)] - 4) * STEP_TIME_PS / CLK_PERIOD_PS;
            check(32'(e >= hi - 20 && e <= hi + 20), 32'h1);
        end
        for (int c = 0; c < 2; c++) begin
            cal_ans <= c[0];
            wr(ba(IDX_SW_DELAY), 32'h85);
            rd(ba(IDX_SW_DELAY));
            check({31'h0, cal_act}, 32'h1);
            for (e = 0; e < 100; e++) begin
                axi_read(ba(IDX_SW_DELAY), rd_word, rd_resp);
                if (rd_word[7] === 1'b0) break;
            end
            check(32'(e < 100), 32'h1);
            ref_reg[ba(IDX_SW_DELAY)] = 8'h05;
            rd(ba(IDX_SW_DELAY));
        end
        finish_test();
    end
endmodule
`default_nettype wire
